// ==== src/tst_ctrl.sv ====
/*
 * Thermal sensor trip controller: two on-die sensor channels with hot trip
 * and hysteresis, thermometer readout with a valid flag, hot-event error
 * interrupt, memory throttling triggers and the latched shutdown output.
 * Assumes sensor codes and external sensor lines arrive asynchronously and
 * change slowly; bandwidth samples come from logic on clk_i.
 */
// Added by the designer: the placing of the registers and register access over Wishbone.
// Contract
// - Per-sensor enable bit and hysteresis field exist
// - Error command bit four enables hot error interrupt
// - Hot error interrupt sets hot flag in source
// - Set hot flag blocks further registration until cleared
// - Global sensor event bit set, software clears it
// - Hot trip flag shows live above-threshold condition
// - Thermometer sequence takes 512 times 256 sensor clocks
// - Reading valid only while valid flag reads one
// - Hysteresis stops trip toggling at threshold
// - Hysteresis offset programmable from 0 to 15
// - Self throttle on sensor trip or bandwidth excess
// - Per-rank bandwidth limited through averaging filter
// - External overtemperature throttles reads on all modules
// - Shutdown assertion stops internal clocks
// - Shutdown stays latched until system reset input
// - Trip crossings in either direction raise events
`timescale 1ns/1ps
module tst_ctrl
#(
   parameter int unsigned SEQ_LEN = tst_pkg::SEQ_CYCLES
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [tst_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire tst_pkg::tst_code_t sensor_code_a_i,
   input wire tst_pkg::tst_code_t sensor_code_b_i,
   input wire logic [tst_pkg::NUM_DIMMS-1:0] ext_overtemp_n_i,
   input wire logic system_reset_in_n_i,
   input wire logic bw_valid_i,
   input wire tst_pkg::tst_code_t bw_sample_i,
   input wire logic rank_valid_i,
   input wire logic [tst_pkg::NUM_RANKS-1:0][tst_pkg::CODE_W-1:0] rank_bw_i,
   output logic self_throttle_o,
   output logic [tst_pkg::NUM_RANKS-1:0] rank_throttle_o,
   output logic read_throttle_o,
   output logic overtemp_shutdown_out_n_o,
   output logic clk_stop_o,
   output logic serr_o,
   output logic irq_o
);
   import tst_pkg::*;

   tst_state_s s;
   tst_state_s next_s;

   // Merge write data into an old word by byte enables
   function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (sel[i])
         begin
            r[8*i +: 8] = wd[8*i +: 8];
         end
      end
      return r;
   endfunction

   // Next hot trip state with hysteresis on release
   function automatic logic hyst_trip(input logic cur, input tst_code_t code,
                                      input tst_code_t thr,
                                      input logic [HYS_W-1:0] hys);
      logic r;
      r = cur;
      if (!cur && code > thr)
      begin
         r = 1'b1;
      end
      else if (cur && ({1'b0, code} + 9'(hys)) < {1'b0, thr})
      begin
         r = 1'b0;
      end
      return r;
   endfunction

   // Weighted averaging filter: avg moves a quarter toward the sample
   function automatic tst_code_t avg_step(input tst_code_t avg,
                                          input tst_code_t smp);
      logic signed [9:0] diff;
      logic signed [9:0] sum;
      diff = $signed({2'b00, smp}) - $signed({2'b00, avg});
      sum = $signed({2'b00, avg}) + (diff >>> AVG_SHIFT);
      return sum[CODE_W-1:0];
   endfunction

   logic acc;
   logic wr;
   logic [31:0] wd;
   logic [31:0] rd;
   logic hot_evt;
   logic cat_hit;

   // Register read multiplexer; unmapped offsets read as zero
   always_comb
   begin
      rd = 32'h0;
      case (wb_adr_i)
         OFS_TRIP_A: rd[CODE_W-1:0] = s.thr_a;
         OFS_TRIP_B: rd[CODE_W-1:0] = s.thr_b;
         OFS_CTRL_A:
         begin
            rd[CTRL_EN_BIT] = s.en_a;
            rd[CTRL_HYS_LSB +: HYS_W] = s.hys_a;
         end
         OFS_CTRL_B:
         begin
            rd[CTRL_EN_BIT] = s.en_b;
            rd[CTRL_HYS_LSB +: HYS_W] = s.hys_b;
         end
         OFS_ERR_CMD: rd[ERR_CMD_SERR_BIT] = s.serr_en;
         OFS_IRQ_SRC: rd[1:0] = s.irq_src;
         OFS_IRQ_MASK: rd[1:0] = s.irq_mask;
         OFS_ERR_STAT: rd[0] = s.err_stat;
         OFS_STATUS: rd[3:0] = {s.valid_b, s.trip_b, s.valid_a, s.trip_a};
         OFS_READING: rd[15:0] = {s.read_b, s.read_a};
         OFS_CAT_THR: rd[CODE_W-1:0] = s.cat_thr;
         OFS_THROTTLE:
         begin
            rd[THR_BW_LSB +: CODE_W] = s.bw_thr;
            rd[THR_RANK_LSB +: CODE_W] = s.rank_lim;
         end
         default: rd = 32'h0;
      endcase
   end

   // Next-state logic for the whole controller
   always_comb
   begin
      next_s = s;
      acc = wb_cyc_i && wb_stb_i && !s.ack;
      wr = acc && wb_we_i;
      wd = lane_merge(rd, wb_dat_i, wb_sel_i);
      next_s.ack = acc;
      if (acc && !wb_we_i)
      begin
         next_s.dat = rd;
      end
      // Two-flop synchronisers for asynchronous inputs
      next_s.code_a_m = sensor_code_a_i;
      next_s.code_a = s.code_a_m;
      next_s.code_b_m = sensor_code_b_i;
      next_s.code_b = s.code_b_m;
      // Codes go on only after two equal samples, never torn mid-change
      next_s.code_a_p = s.code_a;
      next_s.code_a_ok = (s.code_a == s.code_a_p) ? s.code_a : s.code_a_ok;
      next_s.code_b_p = s.code_b;
      next_s.code_b_ok = (s.code_b == s.code_b_p) ? s.code_b : s.code_b_ok;
      next_s.ext_m = ~ext_overtemp_n_i;
      next_s.ext = s.ext_m;
      next_s.sysrst_n_m = system_reset_in_n_i;
      next_s.sysrst_n = s.sysrst_n_m;
      // Register writes; status bits are write-one-to-clear
      if (wr)
      begin
         case (wb_adr_i)
            OFS_TRIP_A: next_s.thr_a = wd[CODE_W-1:0];
            OFS_TRIP_B: next_s.thr_b = wd[CODE_W-1:0];
            OFS_CTRL_A:
            begin
               next_s.en_a = wd[CTRL_EN_BIT];
               next_s.hys_a = wd[CTRL_HYS_LSB +: HYS_W];
            end
            OFS_CTRL_B:
            begin
               next_s.en_b = wd[CTRL_EN_BIT];
               next_s.hys_b = wd[CTRL_HYS_LSB +: HYS_W];
            end
            OFS_ERR_CMD: next_s.serr_en = wd[ERR_CMD_SERR_BIT];
            OFS_IRQ_SRC:
            begin
               if (wb_sel_i[0])
               begin
                  next_s.irq_src = s.irq_src & ~wb_dat_i[1:0];
               end
            end
            OFS_IRQ_MASK: next_s.irq_mask = wd[1:0];
            OFS_ERR_STAT:
            begin
               if (wb_sel_i[0] && wb_dat_i[0])
               begin
                  next_s.err_stat = 1'b0;
               end
            end
            OFS_CAT_THR: next_s.cat_thr = wd[CODE_W-1:0];
            OFS_THROTTLE:
            begin
               next_s.bw_thr = wd[THR_BW_LSB +: CODE_W];
               next_s.rank_lim = wd[THR_RANK_LSB +: CODE_W];
            end
            default: next_s.dat = s.dat;
         endcase
      end
      // Hot trip with hysteresis, only while the sensor is enabled
      next_s.trip_a = s.en_a &&
         hyst_trip(s.trip_a, s.code_a_ok, s.thr_a, s.hys_a);
      next_s.trip_b = s.en_b &&
         hyst_trip(s.trip_b, s.code_b_ok, s.thr_b, s.hys_b);
      // Either crossing direction is an event; flag set wins over clear
      hot_evt = (next_s.trip_a != s.trip_a) ||
                (next_s.trip_b != s.trip_b);
      next_s.serr = 1'b0;
      if (hot_evt && s.serr_en && !s.irq_src[IRQ_HOT_BIT])
      begin
         next_s.serr = 1'b1;
         next_s.irq_src[IRQ_HOT_BIT] = 1'b1;
         next_s.err_stat = 1'b1;
      end
      // Thermometer sequence counters and captured readings
      if (!s.en_a)
      begin
         next_s.cnt_a = '0;
         next_s.valid_a = 1'b0;
      end
      else if (s.cnt_a == CNT_W'(SEQ_LEN - 1))
      begin
         next_s.cnt_a = '0;
         next_s.valid_a = 1'b1;
         next_s.read_a = s.code_a_ok;
      end
      else
      begin
         next_s.cnt_a = s.cnt_a + 1'b1;
      end
      if (!s.en_b)
      begin
         next_s.cnt_b = '0;
         next_s.valid_b = 1'b0;
      end
      else if (s.cnt_b == CNT_W'(SEQ_LEN - 1))
      begin
         next_s.cnt_b = '0;
         next_s.valid_b = 1'b1;
         next_s.read_b = s.code_b_ok;
      end
      else
      begin
         next_s.cnt_b = s.cnt_b + 1'b1;
      end
      // Averaging filters for self and per-rank bandwidth
      if (bw_valid_i)
      begin
         next_s.bw_avg = avg_step(s.bw_avg, bw_sample_i);
      end
      if (rank_valid_i)
      begin
         for (int r = 0; r < NUM_RANKS; r++)
         begin
            next_s.rank_avg[r] = avg_step(s.rank_avg[r], rank_bw_i[r]);
         end
      end
      // Shutdown latch; only the system reset input releases it
      cat_hit = (s.en_a && s.code_a_ok >= s.cat_thr) ||
                (s.en_b && s.code_b_ok >= s.cat_thr);
      if (!s.sysrst_n)
      begin
         next_s.shut = 1'b0;
      end
      else if (cat_hit && !s.shut)
      begin
         next_s.shut = 1'b1;
         next_s.irq_src[IRQ_SHUT_BIT] = 1'b1;
      end
   end

   // State register with synchronous reset
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s <= '0;
         s.thr_a <= RST_TRIP;
         s.thr_b <= RST_TRIP;
         s.cat_thr <= RST_CAT;
         s.bw_thr <= RST_BW_THR;
         s.rank_lim <= RST_RANK_LIM;
         s.irq_mask <= RST_MASK;
         s.sysrst_n_m <= 1'b1;
         s.sysrst_n <= 1'b1;
      end
      else
      begin
         s <= next_s;
      end
   end

   // Outputs
   assign wb_ack_o = s.ack;
   assign wb_dat_o = s.dat;
   assign self_throttle_o = s.trip_a || s.trip_b ||
                            (s.bw_avg > s.bw_thr);
   always_comb
   begin
      for (int r = 0; r < NUM_RANKS; r++)
      begin
         rank_throttle_o[r] = s.rank_avg[r] > s.rank_lim;
      end
   end
   assign read_throttle_o = |s.ext;
   assign overtemp_shutdown_out_n_o = !s.shut;
   assign clk_stop_o = s.shut;
   assign serr_o = s.serr;
   assign irq_o = |(s.irq_src & s.irq_mask);

   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence hot_registered;
      s.serr ##0 s.irq_src[IRQ_HOT_BIT];
   endsequence
   sequence seq_done_a;
      s.en_a && s.cnt_a == CNT_W'(SEQ_LEN - 1);
   endsequence

   a_serr_enable: assert property (s.serr |-> $past(s.serr_en))
      else $error("error interrupt without enable");
   a_hot_flag_set: assert property (s.serr |-> hot_registered)
      else $error("hot flag not set with interrupt");
   a_flag_blocks: assert property (s.serr |-> !$past(s.irq_src[0]))
      else $error("interrupt registered while flag set");
   a_global_event: assert property ($rose(s.irq_src[0]) |->
      s.err_stat)
      else $error("global event bit missing");
   a_trip_live: assert property ($rose(s.trip_a) |->
      $past(s.code_a_ok > s.thr_a))
      else $error("trip set without crossing");
   a_hyst_release: assert property ($fell(s.trip_a) |->
      $past(!s.en_a || ({1'b0, s.code_a_ok} + 9'(s.hys_a)) < {1'b0, s.thr_a}))
      else $error("trip released inside hysteresis band");
   a_seq_valid: assert property (seq_done_a |=> s.valid_a ##0
      s.read_a == $past(s.code_a_ok))
      else $error("sequence end did not validate reading");
   a_valid_drop: assert property (!s.en_a |=> !s.valid_a)
      else $error("reading valid while sensor disabled");
   a_edge_event: assert property ((s.trip_a != $past(s.trip_a)) &&
      $past(s.serr_en && !s.irq_src[0]) |-> s.serr)
      else $error("crossing did not raise event");
   a_shut_latch: assert property (s.shut && s.sysrst_n |=> s.shut)
      else $error("shutdown released without reset");
   a_clk_stop: assert property (s.shut |-> clk_stop_o &&
      !overtemp_shutdown_out_n_o)
      else $error("clocks not stopped on shutdown");
   a_read_thr: assert property ($rose(s.ext[0]) |-> read_throttle_o)
      else $error("read throttle missing");

endmodule

// ==== src/tst_pkg.sv ====
/*
 * Shared constants and carrier types for the thermal sensor trip block:
 * register offsets, field positions, reset values, timing counts and the
 * packed state record of the controller.
 * Assumes a single 20 MHz clock and a 32-bit classic Wishbone register bus.
 */
package tst_pkg;

   // Clock and thermometer sequence timing
   localparam int unsigned CLK_MHZ = 20;
   localparam int unsigned SEQ_SENSOR_CLKS = 512 * 256;
   localparam int unsigned SENSOR_CLK_MHZ = 100;
   // Full sequence time in ns (512 * 256 / 100 MHz)
   localparam int unsigned SEQ_TIME_NS =
      SEQ_SENSOR_CLKS * 1000 / SENSOR_CLK_MHZ;
   // Least time, rounded up to whole clock cycles
   localparam int unsigned SEQ_CYCLES = (SEQ_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned CNT_W = 16;

   // Widths and counts
   localparam int unsigned CODE_W = 8;
   localparam int unsigned HYS_W = 4;
   localparam int unsigned NUM_RANKS = 4;
   localparam int unsigned NUM_DIMMS = 2;
   localparam int unsigned ADR_W = 8;

   // Register byte offsets
   localparam logic [7:0] OFS_TRIP_A = 8'h00;
   localparam logic [7:0] OFS_TRIP_B = 8'h04;
   localparam logic [7:0] OFS_CTRL_A = 8'h08;
   localparam logic [7:0] OFS_CTRL_B = 8'h0c;
   localparam logic [7:0] OFS_ERR_CMD = 8'h10;
   localparam logic [7:0] OFS_IRQ_SRC = 8'h14;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
   localparam logic [7:0] OFS_ERR_STAT = 8'h1c;
   localparam logic [7:0] OFS_STATUS = 8'h20;
   localparam logic [7:0] OFS_READING = 8'h24;
   localparam logic [7:0] OFS_CAT_THR = 8'h28;
   localparam logic [7:0] OFS_THROTTLE = 8'h2c;

   // Field positions
   localparam int unsigned CTRL_EN_BIT = 0;
   localparam int unsigned CTRL_HYS_LSB = 4;
   localparam int unsigned ERR_CMD_SERR_BIT = 4;
   localparam int unsigned IRQ_HOT_BIT = 0;
   localparam int unsigned IRQ_SHUT_BIT = 1;
   localparam int unsigned THR_BW_LSB = 0;
   localparam int unsigned THR_RANK_LSB = 8;
   localparam int unsigned AVG_SHIFT = 2;

   // Reset values
   localparam logic [7:0] RST_TRIP = 8'hff;
   localparam logic [7:0] RST_CAT = 8'hff;
   localparam logic [7:0] RST_BW_THR = 8'hff;
   localparam logic [7:0] RST_RANK_LIM = 8'hff;
   localparam logic [1:0] RST_MASK = 2'h0;

   typedef logic [CODE_W-1:0] tst_code_t;

   // Whole controller state, registered once per clock
   typedef struct packed {
      logic ack;
      logic [31:0] dat;
      tst_code_t thr_a;
      tst_code_t thr_b;
      tst_code_t cat_thr;
      logic en_a;
      logic en_b;
      logic [HYS_W-1:0] hys_a;
      logic [HYS_W-1:0] hys_b;
      logic serr_en;
      logic [1:0] irq_src;
      logic [1:0] irq_mask;
      logic err_stat;
      logic serr;
      tst_code_t code_a_m;
      tst_code_t code_a;
      tst_code_t code_b_m;
      tst_code_t code_b;
      tst_code_t code_a_p;
      tst_code_t code_a_ok;
      tst_code_t code_b_p;
      tst_code_t code_b_ok;
      logic [NUM_DIMMS-1:0] ext_m;
      logic [NUM_DIMMS-1:0] ext;
      logic sysrst_n_m;
      logic sysrst_n;
      logic trip_a;
      logic trip_b;
      logic [CNT_W-1:0] cnt_a;
      logic [CNT_W-1:0] cnt_b;
      logic valid_a;
      logic valid_b;
      tst_code_t read_a;
      tst_code_t read_b;
      tst_code_t bw_thr;
      tst_code_t rank_lim;
      tst_code_t bw_avg;
      logic [NUM_RANKS-1:0][CODE_W-1:0] rank_avg;
      logic shut;
   } tst_state_s;

endpackage

// ==== testbench/testbench.sv ====
/*
 * Self-checking bench for the thermal sensor trip controller: register
 * access, hot trip with hysteresis, error interrupt, thermometer readout,
 * shutdown latch and throttle triggers.
 * Assumes the tst_ctrl design and tst_pkg are compiled first.
 */
`timescale 1ns/1ps
module testbench;
   import tst_pkg::*;

   logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [ADR_W-1:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o;
   tst_code_t sensor_code_a_i, sensor_code_b_i, bw_sample_i;
   logic [NUM_DIMMS-1:0] ext_overtemp_n_i;
   logic system_reset_in_n_i, bw_valid_i, rank_valid_i;
   logic [NUM_RANKS-1:0][CODE_W-1:0] rank_bw_i;
   logic self_throttle_o, read_throttle_o, serr_o, irq_o;
   logic overtemp_shutdown_out_n_o, clk_stop_o;
   logic [NUM_RANKS-1:0] rank_throttle_o;
   int bad_count = 0;
   int samples_checked = 0;
   int serr_cnt = 0;

   tst_ctrl #(.SEQ_LEN(8)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .sensor_code_a_i(sensor_code_a_i), .sensor_code_b_i(sensor_code_b_i),
      .ext_overtemp_n_i(ext_overtemp_n_i),
      .system_reset_in_n_i(system_reset_in_n_i), .bw_valid_i(bw_valid_i),
      .bw_sample_i(bw_sample_i), .rank_valid_i(rank_valid_i),
      .rank_bw_i(rank_bw_i), .self_throttle_o(self_throttle_o),
      .rank_throttle_o(rank_throttle_o), .read_throttle_o(read_throttle_o),
      .overtemp_shutdown_out_n_o(overtemp_shutdown_out_n_o),
      .clk_stop_o(clk_stop_o), .serr_o(serr_o), .irq_o(irq_o));

   // 20 MHz clock
   initial
   begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   // Counts error interrupt pulses
   always @(posedge clk_i)
      if (serr_o === 1'b1)
         serr_cnt++;

   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         $display("wrong value %s expected %h seen %h", what, exp, got);
         bad_count++;
      end
   endtask

   // One classic Wishbone cycle, held until ack is sampled high
   task automatic wb_xfer(input logic we, input logic [7:0] adr,
                          input logic [31:0] wd, output logic [31:0] rd);
      int n;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_sel_i <= 4'hf;
      wb_dat_i <= wd;
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 50);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      if (wb_ack_o !== 1'b1)
      begin
         $display("wrong value bus ack expected 1 seen timeout");
         bad_count++;
         final_report();
      end
   endtask

   task automatic wr(input logic [7:0] adr, input logic [31:0] wd);
      logic [31:0] rd;
      wb_xfer(1'b1, adr, wd, rd);
   endtask

   task automatic rd_chk(input string what, input logic [7:0] adr,
                         input logic [31:0] exp);
      logic [31:0] rd;
      wb_xfer(1'b0, adr, 32'h0, rd);
      chk(what, exp, rd);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   // Moves sensor A code and lets it pass the synchroniser
   task automatic code_a(input tst_code_t c);
      sensor_code_a_i <= c;
      cyc(8);
   endtask

   task automatic pulse_bw();
      repeat (4)
      begin
         @(posedge clk_i);
         bw_valid_i <= 1'b1;
         rank_valid_i <= 1'b1;
         @(posedge clk_i);
         bw_valid_i <= 1'b0;
         rank_valid_i <= 1'b0;
      end
   endtask

   // Main sequence
   initial
   begin
      rst_i = 1'b1;
      {wb_cyc_i, wb_stb_i, wb_we_i, bw_valid_i, rank_valid_i} = 5'h0;
      wb_adr_i = 8'h0;
      wb_sel_i = 4'h0;
      wb_dat_i = 32'h0;
      sensor_code_a_i = 8'h40;
      sensor_code_b_i = 8'h20;
      ext_overtemp_n_i = 2'h3;
      system_reset_in_n_i = 1'b1;
      bw_sample_i = 8'hff;
      rank_bw_i = {8'h00, 8'hff, 8'h00, 8'h00};
      cyc(8);
      rst_i <= 1'b0;
      rd_chk("trip a reset", OFS_TRIP_A, 32'hff);
      rd_chk("mask reset", OFS_IRQ_MASK, 32'h0);
      rd_chk("unmapped", 8'h30, 32'h0);
      wr(OFS_TRIP_A, 32'h50);
      wr(OFS_TRIP_B, 32'h30);
      wr(OFS_CTRL_A, 32'h21);
      wr(OFS_CTRL_B, 32'h01);
      rd_chk("ctrl a", OFS_CTRL_A, 32'h21);
      cyc(20);
      rd_chk("status valid", OFS_STATUS, 32'ha);
      rd_chk("reading", OFS_READING, 32'h2040);
      wr(OFS_ERR_CMD, 32'h10);
      code_a(8'h51);
      chk("serr count rise", 1, serr_cnt);
      chk("self throttle trip", 1, self_throttle_o);
      rd_chk("hot trip set", OFS_STATUS, 32'hb);
      rd_chk("hot src set", OFS_IRQ_SRC, 32'h1);
      rd_chk("err stat set", OFS_ERR_STAT, 32'h1);
      chk("irq masked", 0, irq_o);
      wr(OFS_IRQ_MASK, 32'h1);
      cyc(1);
      chk("irq unmasked", 1, irq_o);
      code_a(8'h50);
      rd_chk("trip held", OFS_STATUS, 32'hb);
      code_a(8'h4d);
      rd_chk("trip released", OFS_STATUS, 32'ha);
      // A one-cycle code glitch must not reach the trip logic
      sensor_code_a_i <= 8'h5f;
      cyc(1);
      code_a(8'h4d);
      rd_chk("glitch ignored", OFS_STATUS, 32'ha);
      chk("serr blocked", 1, serr_cnt);
      wr(OFS_IRQ_SRC, 32'h1);
      wr(OFS_ERR_STAT, 32'h1);
      rd_chk("hot src clear", OFS_IRQ_SRC, 32'h0);
      rd_chk("err stat clear", OFS_ERR_STAT, 32'h0);
      chk("irq cleared", 0, irq_o);
      code_a(8'h51);
      chk("serr rearmed", 2, serr_cnt);
      wr(OFS_IRQ_SRC, 32'h1);
      code_a(8'h4d);
      chk("serr falling", 3, serr_cnt);
      wr(OFS_IRQ_SRC, 32'h1);
      wr(OFS_ERR_CMD, 32'h0);
      code_a(8'h51);
      chk("serr disabled", 3, serr_cnt);
      code_a(8'h40);
      wr(OFS_CAT_THR, 32'h60);
      code_a(8'h60);
      chk("shutdown set", 0, overtemp_shutdown_out_n_o);
      chk("clock stop", 1, clk_stop_o);
      code_a(8'h40);
      chk("shutdown held", 0, overtemp_shutdown_out_n_o);
      system_reset_in_n_i <= 1'b0;
      cyc(5);
      system_reset_in_n_i <= 1'b1;
      cyc(5);
      chk("shutdown clear", 1, overtemp_shutdown_out_n_o);
      chk("clock run", 0, clk_stop_o);
      ext_overtemp_n_i <= 2'h2;
      cyc(5);
      chk("read thr dimm0", 1, read_throttle_o);
      ext_overtemp_n_i <= 2'h1;
      cyc(5);
      chk("read thr dimm1", 1, read_throttle_o);
      ext_overtemp_n_i <= 2'h3;
      cyc(5);
      chk("read thr idle", 0, read_throttle_o);
      chk("self thr idle", 0, self_throttle_o);
      wr(OFS_THROTTLE, 32'h1010);
      pulse_bw();
      cyc(2);
      chk("self thr bw", 1, self_throttle_o);
      chk("rank thr", 32'h4, {28'h0, rank_throttle_o});
      final_report();
   end
endmodule
